// *** src/crf_flt_match.sv ***
`timescale 1ns/1ps
`include "crf_map.svh"
module crf_flt_match (
   input crf_pkg::crf_frame_t frm,
   input wire logic [15:0] f_sid,
   input wire logic [15:0] f_eid,
   input wire logic [15:0] m_sid,
   input wire logic [15:0] m_eid,
   input wire logic en,
   output logic match
);
   import crf_pkg::*;
   logic [28:0] fid, mid, rid, bad;
   logic id_ok, ty_ok;
   // 29-bit identifiers: sid on top, eid below
   assign fid = {f_sid[`CRF_SID_HI:`CRF_SID_LO], f_sid[1:0], f_eid};
   assign mid = {m_sid[`CRF_SID_HI:`CRF_SID_LO], m_sid[1:0], m_eid};
   assign rid = {frm.sid, frm.eid};
   assign bad = mid & (fid ^ rid);
   // standard frames carry no eid, so only sid bits count
   assign id_ok = frm.ide ? (bad == 29'h0) : (bad[28:18] == 11'h0);
   // type check enable on the mask gates the filter's type select
   assign ty_ok = ~m_sid[`CRF_TYPE_BIT] |
                  (f_sid[`CRF_TYPE_BIT] == frm.ide);
   assign match = en & id_ok & ty_ok;
endmodule : crf_flt_match

// *** src/crf_lowest.sv ***
`timescale 1ns/1ps
module crf_lowest #(
   parameter int N = 16,
   parameter int W = 4
) (
   input wire logic [N-1:0] vec,
   output logic any,
   output logic [W-1:0] idx
);
   // scan downward so the lowest set bit is the last to win
   always_comb begin
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (vec[i]) begin
            idx = W'(i);
         end
      end
   end
   assign any = |vec;
endmodule : crf_lowest

// *** src/crf_map.svh ***
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
// Functional notes
// - each filter has a type select at bit 3 of its standard-id register
// - type check on: select 0 takes standard frames, 1 takes extended
// - type check off: type select ignored, any format matching is taken
// - a filter match raises a transfer request toward the DMA controller
// - field 15:13 of fifo control sizes buffer area 4 to 32 buffers
// - destination buffer comes from the pointer of the matching filter
// - four pointer registers hold 4-bit pointers of filters 0 to 15
// - matching filter's pointer is given to the DMA as buffer address
// - pointers 0000 to 1110 select message buffers 0 to 14
// - pointer 1111 sends the message to the receive FIFO area
// - several matches: lowest filter whose target buffer is empty wins
// - buffers 0 to 7 have a direction bit at bit 7 of their control
// - buffers 0 to 7 store a message only when direction bit is 0
// - transmit buffer with auto-remote enabled answers remote requests; the code ignores the frame's rtr bit and answers any matching frame
// - buffers 8 to 14 are receive only, selected by pointer alone
// - window select 1 maps filter registers, 0 the control registers
// - mask bit 0 accepts the bit; mask bit 1 needs equal bits
// - mask select 00, 01, 10 pick masks 0 to 2; 11 reserved
// - a filter takes part only while its enable bit is set
// - target already full: set its overflow flag, drop the message
// control window (window select 0); CRF_CTRL is seen in both windows
`define CRF_CTRL 8'h00
`define CRF_FCTRL 8'h04
`define CRF_FEN 8'h08
`define CRF_TRC0 8'h0c
`define CRF_TRC1 8'h10
`define CRF_FULL 8'h14
`define CRF_OVF 8'h18
`define CRF_STAT 8'h1c
// filter window (window select 1)
`define CRF_BP0 8'h08
`define CRF_BP3 8'h14
`define CRF_MSEL0 8'h18
`define CRF_MSEL1 8'h1c
`define CRF_MASK0 8'h20
`define CRF_MASKE 8'h38
`define CRF_FLT0 8'h80
// field positions
`define CRF_WIN_BIT 0
`define CRF_BCNT_HI 15
`define CRF_BCNT_LO 13
`define CRF_FSA_HI 4
`define CRF_TYPE_BIT 3
`define CRF_SID_HI 15
`define CRF_SID_LO 5
`define CRF_DIR_BIT 7
`define CRF_ARR_BIT 6
`define CRF_TX_REQUEST_BIT 3
`define CRF_BP_FIFO 4'hf
`define CRF_MSK_RSVD 2'h3
// reset values
`define CRF_BCNT_RST 3'h0
`define CRF_FEN_RST 16'h0000
`define CRF_CFG_RST 16'h0000
`endif

// *** src/crf_pkg.sv ***
package crf_pkg;
   // assembled frame handed over by the protocol engine
   typedef struct packed {
      logic ide;
      logic rtr;
      logic [10:0] sid;
      logic [17:0] eid;
   } crf_frame_t;
   // buffer address given to the DMA channel
   typedef struct packed {
      logic fifo;
      logic [4:0] idx;
   } crf_dma_t;
   // wishbone request fields held stable by the master
   typedef struct packed {
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } crf_wb_t;
   typedef enum logic [1:0] {
      CRF_IDLE = 2'b00,
      CRF_EVAL = 2'b01,
      CRF_REQ = 2'b11
   } crf_state_t;
endpackage : crf_pkg

// *** src/crf_top.sv ***
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "crf_map.svh"
module crf_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input crf_pkg::crf_wb_t wb_req,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   input wire logic frm_valid,
   input crf_pkg::crf_frame_t frm,
   output logic frm_ready,
   input wire logic [4:0] fifo_ptr,
   output logic dma_req,
   output crf_pkg::crf_dma_t dma_tgt,
   input wire logic dma_ack,
   output logic rtr_hit,
   output logic [2:0] rtr_buf,
   output logic ovf_hit,
   output logic [4:0] ovf_buf
);
   import crf_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // state
   logic ack_q;
   logic [31:0] rd_q, rd_d;
   logic win_q;
   logic [2:0] bcnt_q;
   logic [4:0] fsa_q;
   logic [15:0] fen_q;
   logic [7:0] trc_q [8];
   logic [31:0] full_q, ovf_q;
   logic [15:0] fsid_q [16];
   logic [15:0] feid_q [16];
   logic [15:0] msid_q [3];
   logic [15:0] meid_q [3];
   logic [3:0] bp_q [16];
   logic [1:0] msel_q [16];
   crf_state_t st_q;
   crf_frame_t frm_q;
   logic rdy_q, req_q, rtr_q, ovf_hit_q;
   crf_dma_t dma_q;
   logic [2:0] rtr_buf_q;
   logic [4:0] ovf_buf_q;

   function automatic logic [31:0] bm32(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
      bm32 = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            bm32[8*b +: 8] = d[8*b +: 8];
         end
      end
   endfunction : bm32

   function automatic logic [15:0] bm16(input logic [15:0] o,
      input logic [15:0] d, input logic [1:0] s);
      bm16 = o;
      if (s[0]) bm16[7:0] = d[7:0];
      if (s[1]) bm16[15:8] = d[15:8];
   endfunction : bm16

   // buffer-count code to number of buffers; 7 spare, read as 32
   function automatic logic [5:0] bsz(input logic [2:0] c);
      unique case (c)
         3'h0: bsz = 6'h04;
         3'h1: bsz = 6'h06;
         3'h2: bsz = 6'h08;
         3'h3: bsz = 6'h0c;
         3'h4: bsz = 6'h10;
         3'h5: bsz = 6'h18;
         default: bsz = 6'h20;
      endcase
   endfunction : bsz

   ////////////////////////////////////////////////////////////////////
   // wishbone decode; the window bit swaps the map except CRF_CTRL
   logic acc, wr, n_hit, bp_hit, ms_hit, mk_hit, fl_hit;
   logic [7:0] adr;
   logic [1:0] bpg, mki;
   logic [3:0] fli;
   assign acc = wb_cyc & wb_stb & ~ack_q;
   assign wr = acc & wb_req.we;
   assign adr = wb_req.adr;
   assign n_hit = ~win_q;
   assign bp_hit = win_q & (adr >= `CRF_BP0) & (adr <= `CRF_BP3);
   assign bpg = 2'(adr[4:2] - 3'h2);
   assign ms_hit = win_q & ((adr == `CRF_MSEL0) | (adr == `CRF_MSEL1));
   assign mk_hit = win_q & (adr >= `CRF_MASK0) & (adr < `CRF_MASKE);
   assign mki = adr[4:3];
   assign fl_hit = win_q & (adr >= `CRF_FLT0);
   assign fli = adr[6:3];

   // one-cycle answer, ack dropped the cycle after
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
         rd_q <= 32'h0;
      end else begin
         ack_q <= acc;
         rd_q <= acc ? rd_d : 32'h0;
      end
   end

   // unmapped addresses read as zero and ignore writes
   always_comb begin
      rd_d = 32'h0;
      if (adr == `CRF_CTRL) begin
         rd_d[`CRF_WIN_BIT] = win_q;
      end else if (n_hit) begin
         unique case (adr)
            `CRF_FCTRL: rd_d = {16'h0, bcnt_q, 8'h0, fsa_q};
            `CRF_FEN: rd_d = {16'h0, fen_q};
            `CRF_TRC0: rd_d = {trc_q[3], trc_q[2], trc_q[1], trc_q[0]};
            `CRF_TRC1: rd_d = {trc_q[7], trc_q[6], trc_q[5], trc_q[4]};
            `CRF_FULL: rd_d = full_q;
            `CRF_OVF: rd_d = ovf_q;
            `CRF_STAT: rd_d = {30'h0, st_q};
            default: rd_d = 32'h0;
         endcase
      end else if (bp_hit) begin
         for (int j = 0; j < 4; j++) begin
            rd_d[4*j +: 4] = bp_q[{bpg, 2'(j)}];
         end
      end else if (ms_hit) begin
         for (int j = 0; j < 8; j++) begin
            rd_d[2*j +: 2] = msel_q[{adr[2], 3'(j)}];
         end
      end else if (mk_hit) begin
         rd_d[15:0] = adr[2] ? meid_q[mki] : msid_q[mki];
      end else if (fl_hit) begin
         rd_d[15:0] = adr[2] ? feid_q[fli] : fsid_q[fli];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control window registers
   logic [31:0] fc_w;
   assign fc_w = bm32({16'h0, bcnt_q, 8'h0, fsa_q}, wb_req.dat,
                      wb_req.sel);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         win_q <= 1'b0;
         bcnt_q <= `CRF_BCNT_RST;
         fsa_q <= 5'h0;
         fen_q <= `CRF_FEN_RST;
      end else if (wr) begin
         if (adr == `CRF_CTRL && wb_req.sel[0]) begin
            win_q <= wb_req.dat[`CRF_WIN_BIT];
         end
         if (n_hit && adr == `CRF_FCTRL) begin
            bcnt_q <= fc_w[`CRF_BCNT_HI:`CRF_BCNT_LO];
            fsa_q <= fc_w[`CRF_FSA_HI:0];
         end
         if (n_hit && adr == `CRF_FEN) begin
            fen_q <= bm16(fen_q, wb_req.dat[15:0], wb_req.sel[1:0]);
         end
      end
   end

   // buffer control bytes; the auto-remote path sets transmit request
   logic rtr_go;
   logic [31:0] tw;
   logic [2:0] rtr_sel;
   always_comb begin
      tw = adr[4] ? {trc_q[7], trc_q[6], trc_q[5], trc_q[4]}
                  : {trc_q[3], trc_q[2], trc_q[1], trc_q[0]};
      tw = bm32(tw, wb_req.dat, wb_req.sel);
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) trc_q[i] <= 8'h0;
      end else begin
         if (wr && n_hit && (adr == `CRF_TRC0 || adr == `CRF_TRC1)) begin
            for (int i = 0; i < 4; i++) begin
               trc_q[{adr[4], 2'(i)}] <= tw[8*i +: 8];
            end
         end
         // set wins over a software write in the same cycle
         if (rtr_go) trc_q[rtr_sel][`CRF_TX_REQUEST_BIT] <= 1'b1;
      end
   end

   // filter window arrays; no reset on contents is needed but kept
   // so that a disabled filter never sees unknown bits
   logic [15:0] bpw, msw;
   always_comb begin
      bpw = 16'h0;
      msw = 16'h0;
      for (int j = 0; j < 4; j++) bpw[4*j +: 4] = bp_q[{bpg, 2'(j)}];
      for (int j = 0; j < 8; j++) msw[2*j +: 2] = msel_q[{adr[2], 3'(j)}];
      bpw = bm16(bpw, wb_req.dat[15:0], wb_req.sel[1:0]);
      msw = bm16(msw, wb_req.dat[15:0], wb_req.sel[1:0]);
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            fsid_q[i] <= `CRF_CFG_RST;
            feid_q[i] <= `CRF_CFG_RST;
            bp_q[i] <= 4'h0;
            msel_q[i] <= 2'h0;
         end
         for (int i = 0; i < 3; i++) begin
            msid_q[i] <= `CRF_CFG_RST;
            meid_q[i] <= `CRF_CFG_RST;
         end
      end else if (wr) begin
         if (bp_hit) begin
            for (int j = 0; j < 4; j++) begin
               bp_q[{bpg, 2'(j)}] <= bpw[4*j +: 4];
            end
         end
         if (ms_hit) begin
            for (int j = 0; j < 8; j++) begin
               msel_q[{adr[2], 3'(j)}] <= msw[2*j +: 2];
            end
         end
         if (mk_hit && adr[2]) meid_q[mki] <=
            bm16(meid_q[mki], wb_req.dat[15:0], wb_req.sel[1:0]);
         if (mk_hit && !adr[2]) msid_q[mki] <=
            bm16(msid_q[mki], wb_req.dat[15:0], wb_req.sel[1:0]);
         if (fl_hit && adr[2]) feid_q[fli] <=
            bm16(feid_q[fli], wb_req.dat[15:0], wb_req.sel[1:0]);
         if (fl_hit && !adr[2]) fsid_q[fli] <=
            bm16(fsid_q[fli], wb_req.dat[15:0], wb_req.sel[1:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // acceptance: sixteen comparators on the latched frame
   logic [15:0] match_v, use_v;
   logic [15:0] arr_v, area_v;
   logic [4:0] tgt_v [16];
   logic pu_any, pm_any, dma_go, ovf_go;
   logic [3:0] pu_idx, pm_idx;
   for (genvar k = 0; k < 16; k++) begin : g_flt
      logic [1:0] ms;
      assign ms = (msel_q[k] == `CRF_MSK_RSVD) ? 2'h0 : msel_q[k];
      crf_flt_match u_m (
         .frm(frm_q),
         .f_sid(fsid_q[k]),
         .f_eid(feid_q[k]),
         .m_sid(msid_q[ms]),
         .m_eid(meid_q[ms]),
         .en(fen_q[k] & (msel_q[k] != `CRF_MSK_RSVD)),
         .match(match_v[k])
      );
   end

   // per-filter target buffer and whether it can take the frame
   always_comb begin
      for (int k = 0; k < 16; k++) begin
         tgt_v[k] = (bp_q[k] == `CRF_BP_FIFO) ? fifo_ptr
                                              : {1'b0, bp_q[k]};
         area_v[k] = {1'b0, tgt_v[k]} < bsz(bcnt_q);
         // buffers 8 and up are receive only
         arr_v[k] = (tgt_v[k] < 5'h8) &&
                    trc_q[tgt_v[k][2:0]][`CRF_DIR_BIT] &&
                    trc_q[tgt_v[k][2:0]][`CRF_ARR_BIT];
         use_v[k] = match_v[k] && area_v[k] &&
                    (arr_v[k] || (((tgt_v[k] >= 5'h8) ||
                    !trc_q[tgt_v[k][2:0]][`CRF_DIR_BIT]) &&
                    !full_q[tgt_v[k]]));
      end
   end

   crf_lowest #(.N(16), .W(4)) u_pu (
      .vec(use_v),
      .any(pu_any),
      .idx(pu_idx)
   );
   crf_lowest #(.N(16), .W(4)) u_pm (
      .vec(match_v),
      .any(pm_any),
      .idx(pm_idx)
   );

   assign rtr_sel = tgt_v[pu_idx][2:0];
   assign rtr_go = (st_q == CRF_EVAL) & pu_any & arr_v[pu_idx];
   assign dma_go = (st_q == CRF_EVAL) & pu_any & ~arr_v[pu_idx];
   // no usable target: the lowest matching filter's buffer overflows
   assign ovf_go = (st_q == CRF_EVAL) & ~pu_any & pm_any &
                   area_v[pm_idx];

   ////////////////////////////////////////////////////////////////////
   // sequencing: latch frame, evaluate, request, wait for the DMA
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= CRF_IDLE;
         frm_q <= '0;
         rdy_q <= 1'b0;
         req_q <= 1'b0;
         dma_q <= '0;
         rtr_q <= 1'b0;
         rtr_buf_q <= 3'h0;
         ovf_hit_q <= 1'b0;
         ovf_buf_q <= 5'h0;
      end else begin
         rtr_q <= 1'b0;
         ovf_hit_q <= 1'b0;
         unique case (st_q)
            CRF_IDLE: begin
               rdy_q <= 1'b1;
               // evaluate only a fully assembled frame
               if (frm_valid && rdy_q) begin
                  frm_q <= frm;
                  rdy_q <= 1'b0;
                  st_q <= CRF_EVAL;
               end
            end
            CRF_EVAL: begin
               if (dma_go) begin
                  req_q <= 1'b1;
                  dma_q.fifo <= bp_q[pu_idx] == `CRF_BP_FIFO;
                  dma_q.idx <= tgt_v[pu_idx];
                  st_q <= CRF_REQ;
               end else begin
                  rtr_q <= rtr_go;
                  rtr_buf_q <= rtr_sel;
                  ovf_hit_q <= ovf_go;
                  ovf_buf_q <= tgt_v[pm_idx];
                  rdy_q <= 1'b1;
                  st_q <= CRF_IDLE;
               end
            end
            CRF_REQ: begin
               // request and address hold until the DMA has the message
               if (dma_ack) begin
                  req_q <= 1'b0;
                  rdy_q <= 1'b1;
                  st_q <= CRF_IDLE;
               end
            end
            default: st_q <= CRF_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // full and overflow flags: write one to clear, hardware set wins
   logic [31:0] full_clr, ovf_clr, full_set, ovf_set;
   assign full_clr = (wr && n_hit && adr == `CRF_FULL) ?
                     bm32(32'h0, wb_req.dat, wb_req.sel) : 32'h0;
   assign ovf_clr = (wr && n_hit && adr == `CRF_OVF) ?
                    bm32(32'h0, wb_req.dat, wb_req.sel) : 32'h0;
   assign full_set = (req_q & dma_ack) ? (32'h1 << dma_q.idx) : 32'h0;
   assign ovf_set = ovf_go ? (32'h1 << tgt_v[pm_idx]) : 32'h0;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         full_q <= 32'h0;
         ovf_q <= 32'h0;
      end else begin
         full_q <= (full_q & ~full_clr) | full_set;
         ovf_q <= (ovf_q & ~ovf_clr) | ovf_set;
      end
   end

   assign wb_ack = ack_q;
   assign wb_dat_r = rd_q;
   assign frm_ready = rdy_q;
   assign dma_req = req_q;
   assign dma_tgt = dma_q;
   assign rtr_hit = rtr_q;
   assign rtr_buf = rtr_buf_q;
   assign ovf_hit = ovf_hit_q;
   assign ovf_buf = ovf_buf_q;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_req_go;
      dma_go |=> dma_req && dma_tgt.idx == $past(tgt_v[pu_idx]);
   endproperty
   a_req_go: assert property (p_req_go)
      else $error("match did not raise dma request");

   property p_req_hold;
      dma_req && !dma_ack |=> dma_req && $stable(dma_tgt);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("dma request dropped or moved early");

   property p_fixed_ptr;
      dma_go && bp_q[pu_idx] != `CRF_BP_FIFO |=>
         !dma_tgt.fifo && dma_tgt.idx[4] == 1'b0;
   endproperty
   a_fixed_ptr: assert property (p_fixed_ptr)
      else $error("fixed pointer not sent as buffer index");

   property p_fifo_ptr;
      dma_go && bp_q[pu_idx] == `CRF_BP_FIFO |=>
         dma_tgt.fifo && dma_tgt.idx == $past(fifo_ptr);
   endproperty
   a_fifo_ptr: assert property (p_fifo_ptr)
      else $error("fifo pointer not used");

   property p_full_set;
      dma_req && dma_ack |=> full_q[$past(dma_tgt.idx)] ##1 !dma_req;
   endproperty
   a_full_set: assert property (p_full_set)
      else $error("stored buffer not marked full");

   property p_ovf;
      ovf_go |=> ovf_hit && ovf_q[ovf_buf] && !dma_req;
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow not flagged");

   property p_rtr;
      rtr_go |=> rtr_hit && !dma_req &&
         trc_q[rtr_buf][`CRF_TX_REQUEST_BIT];
   endproperty
   a_rtr: assert property (p_rtr)
      else $error("remote request not handled");

   property p_dis;
      (match_v & ~fen_q) == 16'h0;
   endproperty
   a_dis: assert property (p_dis)
      else $error("disabled filter matched");

   property p_tx_block;
      dma_req && !dma_tgt.fifo && dma_tgt.idx < 5'h8 |->
         !trc_q[dma_tgt.idx[2:0]][`CRF_DIR_BIT];
   endproperty
   a_tx_block: assert property (p_tx_block)
      else $error("message sent to transmit buffer");
endmodule : crf_top

// *** verification/crf_dma_model.sv ***
`timescale 1ns/1ps
module crf_dma_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic dma_req,
   input crf_pkg::crf_dma_t dma_tgt,
   input wire logic [3:0] lat,
   output logic dma_ack
);
   import crf_pkg::*;
   logic [3:0] cnt_q;
   // takes the buffer address from the block, never its own
   // acks once the words are moved; lat stretches the move
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
         dma_ack <= 1'b0;
      end else begin
         dma_ack <= 1'b0;
         if (dma_req && !dma_ack && cnt_q >= lat) begin
            dma_ack <= 1'b1;
            cnt_q <= 4'h0;
         end else if (dma_req && !dma_ack) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule : crf_dma_model

// *** verification/crf_top_test.sv ***
`timescale 1ns/1ps
`include "crf_map.svh"
module crf_top_test;
   import crf_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   crf_wb_t wb_req = '0;
   logic [31:0] wb_dat_r;
   logic wb_ack;
   logic frm_valid = 1'b0;
   crf_frame_t frm = '0;
   logic frm_ready;
   logic [4:0] fifo_ptr = 5'h05;
   logic dma_req, dma_ack, rtr_hit, ovf_hit;
   crf_dma_t dma_tgt;
   logic [2:0] rtr_buf;
   logic [4:0] ovf_buf;
   logic [3:0] lat = 4'h0;
   int errors = 0;
   int check_count = 0;
   ////////////////////////////////////////////////////////////////////////
   crf_top crf_top_i (.clk(clk), .rst(rst), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_req(wb_req), .wb_dat_r(wb_dat_r),
      .wb_ack(wb_ack), .frm_valid(frm_valid), .frm(frm),
      .frm_ready(frm_ready), .fifo_ptr(fifo_ptr), .dma_req(dma_req),
      .dma_tgt(dma_tgt), .dma_ack(dma_ack), .rtr_hit(rtr_hit),
      .rtr_buf(rtr_buf), .ovf_hit(ovf_hit), .ovf_buf(ovf_buf));
   crf_dma_model crf_dma_model_i (.clk(clk), .rst(rst),
      .dma_req(dma_req), .dma_tgt(dma_tgt), .lat(lat),
      .dma_ack(dma_ack));
   // 200 mhz
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   // one classic cycle; waits for ack, then a one-cycle idle gap
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_req <= '{we, a, 4'hf, d};
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      r = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask : wr
   task rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask : rc
   // result code: {dma, rtr, ovf, buffer field}
   task send(input logic ide, input logic [10:0] sid,
             input logic [31:0] e);
      logic [31:0] g;
      int n;
      n = 0;
      frm_valid <= 1'b1;
      frm <= '{ide, 1'b0, sid, 18'h0};
      do @(posedge clk); while (frm_ready !== 1'b1);
      frm_valid <= 1'b0;
      // rtr and overflow pulses stand only in the cycle after evaluation
      @(posedge clk);
      #1;
      g = {23'h0, dma_req, rtr_hit, ovf_hit, dma_req ? dma_tgt :
           rtr_hit ? {3'h0, rtr_buf} : {1'b0, ovf_buf}};
      chk(g, e);
      do begin
         @(posedge clk);
         n++;
      end while (frm_ready !== 1'b1 && n < 40);
      if (n >= 40) errors++;
   endtask : send
   ////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   // a hang must not stall the run
   initial begin
      #50000;
      errors++;
      finish_test;
   end
   // main sequence; transmit request never set on a receive buffer
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rc(`CRF_FEN, 32'h0);
      rc(8'hfc, 32'h0);
      wr(`CRF_CTRL, 32'h1);
      wr(`CRF_MASK0, 32'hffe8);
      wr(`CRF_FLT0, 32'h2460);
      wr(`CRF_FLT0 + 8'h08, 32'h2468);
      wr(`CRF_FLT0 + 8'h10, 32'h0);
      wr(`CRF_BP0, 32'h3f9a);
      wr(`CRF_MSEL0, 32'hd0);
      rc(`CRF_BP0, 32'h3f9a);
      wr(`CRF_CTRL, 32'h0);
      rc(`CRF_FEN, 32'h0);
      wr(`CRF_FCTRL, 32'h8000);
      rc(`CRF_FCTRL, 32'h8000);
      wr(`CRF_FEN, 32'hf);
      send(1'b0, 11'h123, 32'h10a);
      rc(`CRF_FULL, 32'h400);
      lat <= 4'h6;
      send(1'b0, 11'h123, 32'h125);
      lat <= 4'h0;
      send(1'b1, 11'h123, 32'h109);
      // buffer 5 is full now, so the fifo pointer moves on
      fifo_ptr <= 5'h06;
      send(1'b1, 11'h124, 32'h126);
      wr(`CRF_FEN, 32'hb);
      send(1'b0, 11'h123, 32'h04a);
      rc(`CRF_OVF, 32'h400);
      wr(`CRF_FULL, 32'h400);
      rc(`CRF_FULL, 32'h260);
      wr(`CRF_TRC0, 32'h00c00000);
      wr(`CRF_CTRL, 32'h1);
      wr(`CRF_BP0, 32'h3f92);
      wr(`CRF_CTRL, 32'h0);
      send(1'b0, 11'h123, 32'h082);
      rc(`CRF_TRC0, 32'h00c80000);
      wr(`CRF_TRC0, 32'h00800000);
      send(1'b0, 11'h123, 32'h042);
      finish_test;
   end
endmodule : crf_top_test
